// ===== src/cal_pkg.sv
/*
 contents: register indices, reset values, field widths and command codes shared by the
 calibration correction block and its arithmetic stage.
 assumptions: byte-wide registers reached over a plain strobe port, one converter clock.
*/
// Operation
// - hold 24-bit main and 16-bit auxiliary offset and gain calibration words.
// - main result is (filter output minus offset) times gain over 400000h, clipped to 32 bits.
// - main offset word is twos complement, 800000h most negative to 7fffffh most positive.
// - main offset word is shifted left to align with 32-bit data before subtracting.
// - offset word 000000h gives no offset correction.
// - chopping mode bypasses the main offset word entirely.
// - main offset bytes sit at 07h low, 08h middle, 09h high.
// - auxiliary offset at 17h/18h is aligned to the 24-bit result and subtracted.
// - main gain at 0ah..0ch, low byte first, is straight binary, 400000h is unity.
// - gain factor is gain word over 400000h, 433333h gives 1.05, 3ccccch 0.95.
// - auxiliary gain at 19h/1ah is straight binary, 4000h unity, larger raises gain.
// - main self-calibration shorts amplifier inputs, averages 16 readings, writes main offset.
// - system calibration with inputs shorted externally averages 16 readings into main offset.
// - auxiliary self-calibration shorts inputs, averages 16 readings, writes auxiliary offset.
// - data ready goes high on accepting a main calibration, low when words are stored.
// - auxiliary calibration completion is not shown on data ready.
package cal_pkg;
	localparam logic [7:0] REG_MAIN_OFFSET_LOW  = 8'h07;
	localparam logic [7:0] REG_MAIN_OFFSET_MID  = 8'h08;
	localparam logic [7:0] REG_MAIN_OFFSET_HIGH = 8'h09;
	localparam logic [7:0] REG_MAIN_GAIN_LOW    = 8'h0a;
	localparam logic [7:0] REG_MAIN_GAIN_MID    = 8'h0b;
	localparam logic [7:0] REG_MAIN_GAIN_HIGH   = 8'h0c;
	localparam logic [7:0] REG_AUX_OFFSET_LOW   = 8'h17;
	localparam logic [7:0] REG_AUX_OFFSET_HIGH  = 8'h18;
	localparam logic [7:0] REG_AUX_GAIN_LOW     = 8'h19;
	localparam logic [7:0] REG_AUX_GAIN_HIGH    = 8'h1a;
	localparam logic [7:0] REG_CAL_CONTROL      = 8'h30;
	localparam logic [7:0] REG_CAL_STATUS       = 8'h31;

	localparam int MAIN_WORD_WIDTH = 24;
	localparam int AUX_WORD_WIDTH  = 16;
	localparam int MAIN_DATA_WIDTH = 32;
	localparam int AUX_DATA_WIDTH  = 24;
	localparam int MAIN_ALIGN      = MAIN_DATA_WIDTH - MAIN_WORD_WIDTH;
	localparam int AUX_ALIGN       = AUX_DATA_WIDTH - AUX_WORD_WIDTH;
	localparam int MAIN_GAIN_SHIFT = 22;
	localparam int AUX_GAIN_SHIFT  = 14;

	localparam logic [23:0] MAIN_OFFSET_RESET = 24'h000000;
	localparam logic [23:0] MAIN_GAIN_RESET   = 24'h400000;
	localparam logic [15:0] AUX_OFFSET_RESET  = 16'h0000;
	localparam logic [15:0] AUX_GAIN_RESET    = 16'h4000;

	localparam int          CAL_READINGS     = 16;
	localparam int          CAL_AVG_SHIFT    = 4;
	localparam logic [4:0]  CAL_COUNT_LAST   = 5'h0f;

	localparam logic [1:0]  CMD_MAIN_SELF    = 2'h1;
	localparam logic [1:0]  CMD_MAIN_SYSTEM  = 2'h2;
	localparam logic [1:0]  CMD_AUX_SELF     = 2'h3;

	typedef enum logic [2:0]
	{
		ST_IDLE     = 3'b001,
		ST_MAIN_CAL = 3'b010,
		ST_AUX_CAL  = 3'b100
	} cal_state_type;
endpackage : cal_pkg

// ===== src/cal_scale.sv
/*
 contents: combinational offset subtract, gain scale and saturation for one converter.
 assumptions: offset already aligned by the caller; gain is straight binary.
*/
`timescale 1ns/100ps
`default_nettype none
module cal_scale #(
	parameter int DATA_WIDTH = 32,
	parameter int GAIN_WIDTH = 24,
	parameter int GAIN_SHIFT = 22
) (
	input  wire logic [DATA_WIDTH-1:0] sample,
	input  wire logic [DATA_WIDTH-1:0] offset,
	input  wire logic [GAIN_WIDTH-1:0] gain,
	output logic      [DATA_WIDTH-1:0] result
);
	localparam int DIFF_WIDTH = DATA_WIDTH + 1;
	localparam int PROD_WIDTH = DIFF_WIDTH + GAIN_WIDTH + 1;
	localparam logic signed [PROD_WIDTH-1:0] MAX_CODE = PROD_WIDTH'((64'sd1 <<< (DATA_WIDTH - 1)) - 64'sd1);
	localparam logic signed [PROD_WIDTH-1:0] MIN_CODE = -(PROD_WIDTH'(64'sd1 <<< (DATA_WIDTH - 1)));

	logic signed [DIFF_WIDTH-1:0] diff;
	logic signed [PROD_WIDTH-1:0] product;
	logic signed [PROD_WIDTH-1:0] scaled;

	always_comb
	begin
		// one extra bit keeps the difference exact before scaling
		diff    = $signed({sample[DATA_WIDTH-1], sample}) - $signed({offset[DATA_WIDTH-1], offset});
		product = PROD_WIDTH'(diff) * $signed({1'b0, gain});
		// arithmetic shift floors toward negative infinity
		scaled  = product >>> GAIN_SHIFT;
		if (scaled > MAX_CODE)
			result = MAX_CODE[DATA_WIDTH-1:0];
		else if (scaled < MIN_CODE)
			result = MIN_CODE[DATA_WIDTH-1:0];
		else
			result = scaled[DATA_WIDTH-1:0];
	end
endmodule : cal_scale
`default_nettype wire

// ===== src/adc_calibration_correction.sv
/*
 contents: calibration words, register port, offset calibration sequencer and the
 correction path for the main and auxiliary converters.
 assumptions: filter outputs arrive as one-cycle valid pulses on ref_clk; commands are
 decoded upstream into one-cycle pulses; input selection is owned by the host.
*/
`timescale 1ns/100ps
`default_nettype none
module adc_calibration_correction (
	input  wire logic        ref_clk,
	input  wire logic        srst,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_write,
	input  wire logic        reg_read,
	output logic      [7:0]  reg_rdata,
	input  wire logic        cal_cmd_valid,
	input  wire logic [1:0]  cal_cmd,
	input  wire logic        chop_enable,
	input  wire logic [31:0] main_sample,
	input  wire logic        main_sample_valid,
	input  wire logic [23:0] aux_sample,
	input  wire logic        aux_sample_valid,
	output logic [31:0]      main_result,
	output logic             main_result_valid,
	output logic [23:0]      aux_result,
	output logic             aux_result_valid,
	output logic             main_amp_short,
	output logic             aux_amp_short,
	output logic             data_ready_out
);
	typedef struct packed {
		logic [23:0]            main_offset_word;
		logic [23:0]            main_gain_word;
		logic [15:0]            aux_offset_word;
		logic [15:0]            aux_gain_word;
		cal_pkg::cal_state_type state;
		logic                   self_cal;
		logic [4:0]             count;
		logic signed [35:0]     acc;
		logic [31:0]            main_result;
		logic                   main_result_valid;
		logic [23:0]            aux_result;
		logic                   aux_result_valid;
		logic                   cal_busy;
		logic [7:0]             rdata;
	} state_type;

	state_type cur;
	state_type next_cur;

	logic [31:0] main_offset_aligned;
	logic [23:0] aux_offset_aligned;
	logic [31:0] main_corrected;
	logic [23:0] aux_corrected;
	logic        cal_done;

	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (srst);

	// chopping removes offset by itself, so the stored word is ignored there
	// a zero word aligns to zero and subtracts nothing
	assign main_offset_aligned = chop_enable ? 32'h00000000
		: {cur.main_offset_word, {cal_pkg::MAIN_ALIGN{1'b0}}};
	assign aux_offset_aligned = {cur.aux_offset_word, {cal_pkg::AUX_ALIGN{1'b0}}};

	cal_scale #(
		.DATA_WIDTH (cal_pkg::MAIN_DATA_WIDTH),
		.GAIN_WIDTH (cal_pkg::MAIN_WORD_WIDTH),
		.GAIN_SHIFT (cal_pkg::MAIN_GAIN_SHIFT)
	) u_main_scale (
		.sample (main_sample),
		.offset (main_offset_aligned),
		.gain   (cur.main_gain_word),
		.result (main_corrected)
	);

	cal_scale #(
		.DATA_WIDTH (cal_pkg::AUX_DATA_WIDTH),
		.GAIN_WIDTH (cal_pkg::AUX_WORD_WIDTH),
		.GAIN_SHIFT (cal_pkg::AUX_GAIN_SHIFT)
	) u_aux_scale (
		.sample (aux_sample),
		.offset (aux_offset_aligned),
		.gain   (cur.aux_gain_word),
		.result (aux_corrected)
	);

	assign cal_done = (cur.state != cal_pkg::ST_IDLE) && (cur.count == cal_pkg::CAL_COUNT_LAST)
		&& (cur.state == cal_pkg::ST_MAIN_CAL ? main_sample_valid : aux_sample_valid);

	always_comb
	begin
		next_cur = cur;
		next_cur.main_result_valid = 1'b0;
		next_cur.aux_result_valid = 1'b0;
		next_cur.rdata = 8'h00;

		// results are held back while their converter is calibrating
		if (main_sample_valid && cur.state != cal_pkg::ST_MAIN_CAL)
		begin
			next_cur.main_result = main_corrected;
			next_cur.main_result_valid = 1'b1;
		end
		if (aux_sample_valid && cur.state != cal_pkg::ST_AUX_CAL)
		begin
			next_cur.aux_result = aux_corrected;
			next_cur.aux_result_valid = 1'b1;
		end

		if (reg_write)
		begin
			case (reg_addr)
				cal_pkg::REG_MAIN_OFFSET_LOW:  next_cur.main_offset_word[7:0]   = reg_wdata;
				cal_pkg::REG_MAIN_OFFSET_MID:  next_cur.main_offset_word[15:8]  = reg_wdata;
				cal_pkg::REG_MAIN_OFFSET_HIGH: next_cur.main_offset_word[23:16] = reg_wdata;
				cal_pkg::REG_MAIN_GAIN_LOW:    next_cur.main_gain_word[7:0]     = reg_wdata;
				cal_pkg::REG_MAIN_GAIN_MID:    next_cur.main_gain_word[15:8]    = reg_wdata;
				cal_pkg::REG_MAIN_GAIN_HIGH:   next_cur.main_gain_word[23:16]   = reg_wdata;
				cal_pkg::REG_AUX_OFFSET_LOW:   next_cur.aux_offset_word[7:0]    = reg_wdata;
				cal_pkg::REG_AUX_OFFSET_HIGH:  next_cur.aux_offset_word[15:8]   = reg_wdata;
				cal_pkg::REG_AUX_GAIN_LOW:     next_cur.aux_gain_word[7:0]      = reg_wdata;
				cal_pkg::REG_AUX_GAIN_HIGH:    next_cur.aux_gain_word[15:8]     = reg_wdata;
				default: ;
			endcase
		end

		if (reg_read)
		begin
			case (reg_addr)
				cal_pkg::REG_MAIN_OFFSET_LOW:  next_cur.rdata = cur.main_offset_word[7:0];
				cal_pkg::REG_MAIN_OFFSET_MID:  next_cur.rdata = cur.main_offset_word[15:8];
				cal_pkg::REG_MAIN_OFFSET_HIGH: next_cur.rdata = cur.main_offset_word[23:16];
				cal_pkg::REG_MAIN_GAIN_LOW:    next_cur.rdata = cur.main_gain_word[7:0];
				cal_pkg::REG_MAIN_GAIN_MID:    next_cur.rdata = cur.main_gain_word[15:8];
				cal_pkg::REG_MAIN_GAIN_HIGH:   next_cur.rdata = cur.main_gain_word[23:16];
				cal_pkg::REG_AUX_OFFSET_LOW:   next_cur.rdata = cur.aux_offset_word[7:0];
				cal_pkg::REG_AUX_OFFSET_HIGH:  next_cur.rdata = cur.aux_offset_word[15:8];
				cal_pkg::REG_AUX_GAIN_LOW:     next_cur.rdata = cur.aux_gain_word[7:0];
				cal_pkg::REG_AUX_GAIN_HIGH:    next_cur.rdata = cur.aux_gain_word[15:8];
				cal_pkg::REG_CAL_STATUS:       next_cur.rdata = {5'h00, cur.state};
				default:                       next_cur.rdata = 8'h00;
			endcase
		end

		case (cur.state)
			cal_pkg::ST_IDLE:
			begin
				next_cur.count = 5'h00;
				next_cur.acc = '0;
				if (cal_cmd_valid)
				begin
					case (cal_cmd)
						cal_pkg::CMD_MAIN_SELF, cal_pkg::CMD_MAIN_SYSTEM:
						begin
							// host has already opened or externally shorted the inputs
							next_cur.state = cal_pkg::ST_MAIN_CAL;
							next_cur.self_cal = (cal_cmd == cal_pkg::CMD_MAIN_SELF);
							next_cur.cal_busy = 1'b1;
						end
						cal_pkg::CMD_AUX_SELF:
						begin
							next_cur.state = cal_pkg::ST_AUX_CAL;
							next_cur.self_cal = 1'b1;
						end
						default: ;
					endcase
				end
			end
			cal_pkg::ST_MAIN_CAL:
			begin
				// raw readings are averaged; the old word must not bias the new one
				if (main_sample_valid)
				begin
					next_cur.acc = cur.acc + 36'(signed'(main_sample));
					next_cur.count = cur.count + 5'h01;
				end
				if (cal_done)
				begin
					next_cur.acc = cur.acc + 36'(signed'(main_sample));
					next_cur.main_offset_word = next_cur.acc[35:12];
					next_cur.state = cal_pkg::ST_IDLE;
					next_cur.cal_busy = 1'b0;
					next_cur.self_cal = 1'b0;
				end
			end
			cal_pkg::ST_AUX_CAL:
			begin
				if (aux_sample_valid)
				begin
					next_cur.acc = cur.acc + 36'(signed'(aux_sample));
					next_cur.count = cur.count + 5'h01;
				end
				if (cal_done)
				begin
					// completion is silent on data ready; host waits the calibration time
					next_cur.acc = cur.acc + 36'(signed'(aux_sample));
					next_cur.aux_offset_word = next_cur.acc[27:12];
					next_cur.state = cal_pkg::ST_IDLE;
					next_cur.self_cal = 1'b0;
				end
			end
			default:
			begin
				next_cur.state = cal_pkg::ST_IDLE;
				next_cur.cal_busy = 1'b0;
			end
		endcase
	end

	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			cur <= '0;
			cur.main_offset_word <= cal_pkg::MAIN_OFFSET_RESET;
			cur.main_gain_word <= cal_pkg::MAIN_GAIN_RESET;
			cur.aux_offset_word <= cal_pkg::AUX_OFFSET_RESET;
			cur.aux_gain_word <= cal_pkg::AUX_GAIN_RESET;
			cur.state <= cal_pkg::ST_IDLE;
		end
		else
			cur <= next_cur;
	end

	assign reg_rdata = cur.rdata;
	assign main_result = cur.main_result;
	assign main_result_valid = cur.main_result_valid;
	assign aux_result = cur.aux_result;
	assign aux_result_valid = cur.aux_result_valid;
	assign main_amp_short = (cur.state == cal_pkg::ST_MAIN_CAL) && cur.self_cal;
	assign aux_amp_short = (cur.state == cal_pkg::ST_AUX_CAL);
	assign data_ready_out = cur.cal_busy;

	property p_main_busy_on_cmd;
		@(posedge ref_clk) disable iff (srst)
		(cur.state == cal_pkg::ST_IDLE && cal_cmd_valid && cal_cmd == cal_pkg::CMD_MAIN_SELF)
			|=> data_ready_out && main_amp_short;
	endproperty
	a_p_main_busy_on_cmd: assert property (p_main_busy_on_cmd) else $error("main cal not started");

	property p_aux_no_ready;
		@(posedge ref_clk) disable iff (srst)
		(cur.state == cal_pkg::ST_AUX_CAL) |-> !data_ready_out;
	endproperty
	a_p_aux_no_ready: assert property (p_aux_no_ready) else $error("aux cal shown on data ready");

	property p_main_done_store;
		@(posedge ref_clk) disable iff (srst)
		(cal_done && cur.state == cal_pkg::ST_MAIN_CAL) |=> !data_ready_out
			&& cur.main_offset_word == $past(next_cur.acc[35:12]);
	endproperty
	a_p_main_done_store: assert property (p_main_done_store) else $error("main offset not stored");

	property p_chop_bypass;
		@(posedge ref_clk) disable iff (srst)
		chop_enable |-> main_offset_aligned == 32'h00000000;
	endproperty
	a_p_chop_bypass: assert property (p_chop_bypass) else $error("offset used in chop mode");

	property p_unity_identity;
		@(posedge ref_clk) disable iff (srst)
		(main_offset_aligned == 32'h00000000 && cur.main_gain_word == cal_pkg::MAIN_GAIN_RESET)
			|-> main_corrected == main_sample;
	endproperty
	a_p_unity_identity: assert property (p_unity_identity) else $error("unity path altered data");

	property p_aux_unity;
		@(posedge ref_clk) disable iff (srst)
		(cur.aux_offset_word == 16'h0000 && cur.aux_gain_word == cal_pkg::AUX_GAIN_RESET)
			|-> aux_corrected == aux_sample;
	endproperty
	a_p_aux_unity: assert property (p_aux_unity) else $error("aux unity path altered data");

	property p_offset_align;
		@(posedge ref_clk) disable iff (srst)
		!chop_enable |-> main_offset_aligned[31:8] == cur.main_offset_word && main_offset_aligned[7:0] == 8'h00;
	endproperty
	a_p_offset_align: assert property (p_offset_align) else $error("offset misaligned");

	property p_write_low;
		@(posedge ref_clk) disable iff (srst)
		(reg_write && reg_addr == cal_pkg::REG_MAIN_OFFSET_LOW && cur.state == cal_pkg::ST_IDLE)
			|=> cur.main_offset_word[7:0] == $past(reg_wdata);
	endproperty
	a_p_write_low: assert property (p_write_low) else $error("offset low byte not written");

	property p_result_follows;
		@(posedge ref_clk) disable iff (srst)
		(main_sample_valid && cur.state != cal_pkg::ST_MAIN_CAL)
			|=> main_result_valid && main_result == $past(main_corrected);
	endproperty
	a_p_result_follows: assert property (p_result_follows) else $error("main result not updated");

	sequence s_main_cmd;
		cur.state == cal_pkg::ST_IDLE && cal_cmd_valid
			&& (cal_cmd == cal_pkg::CMD_MAIN_SELF || cal_cmd == cal_pkg::CMD_MAIN_SYSTEM);
	endsequence

	sequence s_main_running;
		cur.state == cal_pkg::ST_MAIN_CAL && data_ready_out;
	endsequence

	sequence s_aux_cmd;
		cur.state == cal_pkg::ST_IDLE && cal_cmd_valid && cal_cmd == cal_pkg::CMD_AUX_SELF;
	endsequence

	sequence s_aux_running;
		cur.state == cal_pkg::ST_AUX_CAL && aux_amp_short && !data_ready_out;
	endsequence

	// system calibration must flag data ready exactly like self-calibration
	property p_main_cmd_start;
		s_main_cmd |=> s_main_running;
	endproperty
	a_p_main_cmd_start: assert property (p_main_cmd_start) else $error("main cal start not flagged");

	property p_aux_cmd_start;
		s_aux_cmd |=> s_aux_running;
	endproperty
	a_p_aux_cmd_start: assert property (p_aux_cmd_start) else $error("aux cal start wrong");

	property p_cal_finish;
		cal_done |=> cur.state == cal_pkg::ST_IDLE && !data_ready_out && !main_amp_short && !aux_amp_short;
	endproperty
	a_p_cal_finish: assert property (p_cal_finish) else $error("calibration did not finish");

	property p_main_result_held;
		cur.state == cal_pkg::ST_MAIN_CAL |=> !main_result_valid;
	endproperty
	a_p_main_result_held: assert property (p_main_result_held) else $error("main result during cal");

	property p_aux_result_held;
		cur.state == cal_pkg::ST_AUX_CAL |=> !aux_result_valid;
	endproperty
	a_p_aux_result_held: assert property (p_aux_result_held) else $error("aux result during cal");

	property p_count_bound;
		cur.state != cal_pkg::ST_IDLE |-> cur.count <= cal_pkg::CAL_COUNT_LAST;
	endproperty
	a_p_count_bound: assert property (p_count_bound) else $error("reading count overran");

	property p_aux_align;
		aux_offset_aligned[23:8] == cur.aux_offset_word && aux_offset_aligned[7:0] == 8'h00;
	endproperty
	a_p_aux_align: assert property (p_aux_align) else $error("aux offset misaligned");

	property p_rdata_quiet;
		!reg_read |=> reg_rdata == 8'h00;
	endproperty
	a_p_rdata_quiet: assert property (p_rdata_quiet) else $error("read data without read");
endmodule : adc_calibration_correction
`default_nettype wire

// ===== bench/host_model.sv
/*
 host side of the calibration block: register writes and reads and calibration commands.
 assumes the block samples its strobes on the rising edge of ref_clk and answers reads one cycle later.
*/
`timescale 1ns/100ps
`default_nettype none
module host_model (
	input  wire logic       ref_clk,
	input  wire logic [7:0] reg_rdata,
	output var logic  [7:0] reg_addr,
	output var logic  [7:0] reg_wdata,
	output var logic        reg_write,
	output var logic        reg_read,
	output var logic        cal_cmd_valid,
	output var logic  [1:0] cal_cmd
);
	logic [7:0] main_input_select;
	logic [7:0] aux_input_select;
	initial
	begin
		{reg_addr, reg_wdata, reg_write, reg_read, cal_cmd_valid, cal_cmd} = '0;
		main_input_select = 8'h00;
		aux_input_select  = 8'h00;
	end
	// released lines show the inverse so a stale value is never mistaken for a held one
	task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
		@(posedge ref_clk);
		reg_addr  <= addr;
		reg_wdata <= data;
		reg_write <= 1'b1;
		@(posedge ref_clk);
		reg_write <= 1'b0;
		reg_addr  <= ~addr;
		reg_wdata <= ~data;
	endtask : write_reg
	task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
		@(posedge ref_clk);
		reg_addr <= addr;
		reg_read <= 1'b1;
		@(posedge ref_clk);
		reg_read <= 1'b0;
		reg_addr <= ~addr;
		@(posedge ref_clk);
		data = reg_rdata;
	endtask : read_reg
	// only offset calibration is issued, so it always precedes any full-scale one
	task automatic send_cmd(input logic [1:0] cmd);
		if (cmd == 2'h1)
			main_input_select = 8'hff;
		if (cmd == 2'h3)
			aux_input_select = 8'hff;
		@(posedge ref_clk);
		cal_cmd       <= cmd;
		cal_cmd_valid <= 1'b1;
		@(posedge ref_clk);
		cal_cmd_valid <= 1'b0;
		cal_cmd       <= ~cmd;
	endtask : send_cmd
	task automatic restore_select();
		main_input_select = 8'h00;
		aux_input_select  = 8'h00;
	endtask : restore_select
endmodule : host_model
`default_nettype wire

// ===== bench/tb_top.sv
/*
 self-checking bench for the calibration correction block: registers, correction path, offset calibration.
 assumes host_model drives the register port and commands; the bench plays the converter filters.
*/
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	logic        ref_clk = 1'b0;
	logic        srst = 1'b1;
	logic        chop_enable = 1'b0;
	logic [31:0] main_sample = '0;
	logic        main_sample_valid = 1'b0;
	logic [23:0] aux_sample = '0;
	logic        aux_sample_valid = 1'b0;
	logic [7:0]  reg_addr, reg_wdata, reg_rdata;
	logic        reg_write, reg_read, cal_cmd_valid;
	logic [1:0]  cal_cmd;
	logic [31:0] main_result;
	logic [23:0] aux_result;
	logic        main_result_valid, aux_result_valid, main_amp_short, aux_amp_short, data_ready_out;
	logic [31:0] main_q[$];
	logic [31:0] aux_q[$];
	logic [31:0] seed = 32'h00000046;
	logic [31:0] aux_exp;
	logic [23:0] mofs, mgain;
	logic [15:0] aofs, again;
	int          fail_count = 0;
	int          total_checks = 0;
	localparam logic [7:0] addrs[11] = '{8'h07, 8'h08, 8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h17, 8'h18, 8'h19, 8'h1a, 8'h30};
	localparam logic [7:0] rstv[11]  = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h40, 8'h00, 8'h00, 8'h00, 8'h40, 8'h00};
	always #2 ref_clk = ~ref_clk;
	adc_calibration_correction i_adc_calibration_correction (.ref_clk(ref_clk), .srst(srst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
		.cal_cmd_valid(cal_cmd_valid), .cal_cmd(cal_cmd), .chop_enable(chop_enable), .main_sample(main_sample),
		.main_sample_valid(main_sample_valid), .aux_sample(aux_sample), .aux_sample_valid(aux_sample_valid),
		.main_result(main_result), .main_result_valid(main_result_valid), .aux_result(aux_result),
		.aux_result_valid(aux_result_valid), .main_amp_short(main_amp_short), .aux_amp_short(aux_amp_short),
		.data_ready_out(data_ready_out));
	host_model i_host_model (.ref_clk(ref_clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_write(reg_write), .reg_read(reg_read), .cal_cmd_valid(cal_cmd_valid), .cal_cmd(cal_cmd));
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs
	// wide signed arithmetic so the floor and the clip are exact
	function automatic logic [31:0] scale(longint s, longint ofs, longint g, int sh, int w);
		longint d;
		longint lim;
		lim = longint'(1) <<< (w - 1);
		d = ((s - (ofs <<< 8)) * g) >>> sh;
		if (d >= lim)
			d = lim - 1;
		if (d < -lim)
			d = -lim;
		return d[31:0];
	endfunction : scale
	task automatic chk_val(input string name, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp)
		begin
			fail_count++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask : chk_val
	task automatic chk_flag(input string name, input logic exp, input logic got);
		total_checks++;
		if (got !== exp)
		begin
			fail_count++;
			$display("Error %s expected %b seen %b", name, exp, got);
		end
	endtask : chk_flag
	task automatic final_report();
		chk_val("pending results", 32'h0, 32'(main_q.size() + aux_q.size()));
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : final_report
	task automatic set_words();
		for (int i = 0; i < 3; i++)
		begin
			i_host_model.write_reg(cal_pkg::REG_MAIN_OFFSET_LOW + 8'(i), mofs[8*i+:8]);
			i_host_model.write_reg(cal_pkg::REG_MAIN_GAIN_LOW + 8'(i), mgain[8*i+:8]);
		end
		for (int i = 0; i < 2; i++)
		begin
			i_host_model.write_reg(cal_pkg::REG_AUX_OFFSET_LOW + 8'(i), aofs[8*i+:8]);
			i_host_model.write_reg(cal_pkg::REG_AUX_GAIN_LOW + 8'(i), again[8*i+:8]);
		end
	endtask : set_words
	task automatic drive(input logic main_side, input logic [31:0] s, input logic expect_result);
		if (main_side && expect_result)
			main_q.push_back(scale(longint'($signed(s)), chop_enable ? 0 : longint'($signed(mofs)),
				longint'({40'h0, mgain}), 22, 32));
		if (!main_side && expect_result)
			aux_q.push_back(scale(longint'($signed(s[23:0])), longint'($signed(aofs)),
				longint'({48'h0, again}), 14, 24));
		@(posedge ref_clk);
		if (main_side)
		begin
			main_sample       <= s;
			main_sample_valid <= 1'b1;
		end
		else
		begin
			aux_sample       <= s[23:0];
			aux_sample_valid <= 1'b1;
		end
		@(posedge ref_clk);
		main_sample_valid <= 1'b0;
		aux_sample_valid  <= 1'b0;
		main_sample       <= ~main_sample;
		aux_sample        <= ~aux_sample;
	endtask : drive
	always @(posedge ref_clk)
	begin
		if (main_result_valid === 1'b1)
			chk_val("main_result", main_q.size() ? main_q.pop_front() : 'x, main_result);
		if (aux_result_valid === 1'b1)
		begin
			aux_exp = aux_q.size() ? aux_q.pop_front() : 'x;
			chk_val("aux_result", {8'h0, aux_exp[23:0]}, {8'h0, aux_result});
		end
	end
	initial
	begin
		#20000;
		fail_count++;
		final_report();
	end
	initial
	begin
		logic [7:0]  d;
		logic [7:0]  v[11];
		logic [31:0] s;
		logic [23:0] got;
		longint      sum;
		repeat (2) @(posedge ref_clk);
		srst <= 1'b0;
		foreach (addrs[i])
		begin
			i_host_model.read_reg(addrs[i], d);
			chk_val("reset value", {24'h0, rstv[i]}, {24'h0, d});
		end
		foreach (addrs[i])
		begin
			v[i] = 8'(xs());
			i_host_model.write_reg(addrs[i], v[i]);
		end
		foreach (addrs[i])
		begin
			i_host_model.read_reg(addrs[i], d);
			chk_val("register readback", (i == 10) ? 32'h0 : {24'h0, v[i]}, {24'h0, d});
		end
		for (int k = 0; k < 8; k++)
		begin
			case (k)
				0: {mofs, mgain, aofs, again} = {24'h000000, 24'h400000, 16'h0000, 16'h4000};
				1: {mofs, mgain, aofs, again} = {24'h800000, 24'h433333, 16'h8000, 16'hffff};
				2: {mofs, mgain, aofs, again} = {24'h7fffff, 24'h3ccccc, 16'h7fff, 16'h2000};
				3: {mofs, mgain, aofs, again} = {24'h000001, 24'h400000, 16'h0001, 16'h4001};
				default: {mofs, mgain, aofs, again} = {24'(xs()), 24'(xs()), 16'(xs()), 16'(xs())};
			endcase
			set_words();
			for (int c = 0; c < 2; c++)
			begin
				@(posedge ref_clk);
				chop_enable <= c[0];
				@(posedge ref_clk);
				foreach (addrs[j])
					if (j < 3)
						drive(1'b1, (j == 0) ? xs() : ((j == 1) ? 32'h7fffffff : 32'h80000000), 1'b1);
				for (int j = 0; j < 3; j++)
					drive(1'b0, (j == 0) ? xs() : ((j == 1) ? 32'h007fffff : 32'h00800000), 1'b1);
			end
		end
		@(posedge ref_clk);
		chop_enable <= 1'b0;
		for (int cmd = 1; cmd < 4; cmd++)
		begin
			i_host_model.send_cmd(2'(cmd));
			@(posedge ref_clk);
			chk_flag("data_ready_out", cmd != 3, data_ready_out);
			chk_flag("main_amp_short", cmd == 1, main_amp_short);
			chk_flag("aux_amp_short", cmd == 3, aux_amp_short);
			i_host_model.read_reg(cal_pkg::REG_CAL_STATUS, d);
			chk_val("cal_status", (cmd == 3) ? 32'h4 : 32'h2, {24'h0, d});
			sum = 0;
			for (int j = 0; j < 16; j++)
			begin
				s = xs();
				sum += (cmd == 3) ? longint'($signed(s[23:0])) : longint'($signed(s));
				drive(cmd != 3, s, 1'b0);
				chk_flag("data_ready_out", cmd != 3, data_ready_out);
			end
			repeat (2) @(posedge ref_clk);
			chk_flag("data_ready_out", 1'b0, data_ready_out);
			got = '0;
			for (int i = 0; i < 3; i++)
			begin
				i_host_model.read_reg(((cmd == 3) ? cal_pkg::REG_AUX_OFFSET_LOW : cal_pkg::REG_MAIN_OFFSET_LOW) + 8'(i), d);
				got[8*i+:8] = d;
			end
			if (cmd == 3)
				chk_val("aux_offset_word", {16'h0, 16'(sum >>> 12)}, {16'h0, got[15:0]});
			else
				chk_val("main_offset_word", {8'h0, 24'(sum >>> 12)}, {8'h0, got});
			i_host_model.restore_select();
			if (cmd == 3)
				aofs = got[15:0];
			else
				mofs = got;
			drive(cmd != 3, xs(), 1'b1);
		end
		repeat (4) @(posedge ref_clk);
		// a second reset must bring every word back to its reset value
		srst <= 1'b1;
		repeat (2) @(posedge ref_clk);
		srst <= 1'b0;
		foreach (addrs[i])
		begin
			i_host_model.read_reg(addrs[i], d);
			chk_val("reset value", {24'h0, rstv[i]}, {24'h0, d});
		end
		chk_flag("data_ready_out", 1'b0, data_ready_out);
		final_report();
	end
endmodule : tb_top
`default_nettype wire
